// file: rtl/cbm_pkg.sv
// Package for the block-move, stack-pointer load and negate execution unit.
// Assumes one 100 MHz clock; timing counted in CPU clock states (one per mclk).
package cbm_pkg;
  // ------------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_NOP       = 8'h00;
  localparam logic [7:0] OP_LD_SP_PP  = 8'hF9;
  localparam logic [7:0] OP_PFX_ED    = 8'hED;
  localparam logic [7:0] OP_PFX_IX    = 8'hDD;
  localparam logic [7:0] OP_PFX_IY    = 8'hFD;
  localparam logic [7:0] OP_CPY_ASC   = 8'hA0;
  localparam logic [7:0] OP_CPY_DSC   = 8'hA8;
  localparam logic [7:0] OP_CPY_ASC_R = 8'hB0;
  localparam logic [7:0] OP_CPY_DSC_R = 8'hB8;
  localparam logic [7:0] OP_NEG       = 8'h44;
  localparam logic [7:0] ACC_MIN      = 8'h80;
  // ------------------------------------------------------------------
  // Flag bit positions
  // ------------------------------------------------------------------
  localparam int FLG_C  = 0;
  localparam int FLG_N  = 1;
  localparam int FLG_PV = 2;
  localparam int FLG_H  = 4;
  localparam int FLG_Z  = 6;
  localparam int FLG_S  = 7;
  // ------------------------------------------------------------------
  // Clock-state counts
  // ------------------------------------------------------------------
  localparam logic [4:0] T_REG_LD   = 5'h04;
  localparam logic [4:0] T_SP_PP    = 5'h06;
  localparam logic [4:0] T_SP_IDX   = 5'h0A;
  localparam logic [4:0] T_NEG      = 5'h08;
  localparam logic [4:0] T_CPY      = 5'h10;
  localparam logic [4:0] T_CPY_RPT  = 5'h15;
  localparam logic [4:0] T_RD_AT    = 5'h08;
  localparam logic [4:0] T_WR_AT    = 5'h0B;
  localparam logic [1:0] REFRESH_N  = 2'h2;
  localparam logic [15:0] PC_REWIND = 16'h0002;
  // ------------------------------------------------------------------
  // APB map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] A_CMD  = 8'h00;
  localparam logic [7:0] A_ACC  = 8'h04;
  localparam logic [7:0] A_FLG  = 8'h08;
  localparam logic [7:0] A_PP   = 8'h0C;
  localparam logic [7:0] A_DP   = 8'h10;
  localparam logic [7:0] A_BC   = 8'h14;
  localparam logic [7:0] A_IX   = 8'h18;
  localparam logic [7:0] A_IY   = 8'h1C;
  localparam logic [7:0] A_SP   = 8'h20;
  localparam logic [7:0] A_PC   = 8'h24;
  localparam logic [7:0] A_STAT = 8'h28;
  localparam logic [7:0] A_RFSH = 8'h2C;
  localparam logic [7:0] A_MEMD = 8'h30;
  typedef enum logic [2:0] {
    CBM_IDLE  = 3'b000,
    CBM_EXEC  = 3'b001,
    CBM_MRD   = 3'b010,
    CBM_MWR   = 3'b011,
    CBM_DONE  = 3'b100
  } cbm_state_t;
endpackage : cbm_pkg

// file: rtl/cbm_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and active-low asynchronous reset.
`timescale 1ns/1ps
module cbm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : cbm_fifo

// file: rtl/cbm_exec.sv
// Execution unit for register loads, stack-pointer loads, block copies,
// negate and no-operation, with an APB register file and a memory port.
// Assumes a memory that answers mem_rd_valid some cycles after a read.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module cbm_exec (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Memory port
  output logic      [15:0] mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic      [7:0]  mem_wdata,
  input  wire logic        mem_rd_valid,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_wr_ready,
  // Core joins
  input  wire logic        int_request,
  output logic             int_window,
  output logic             refresh_strobe,
  output logic             busy
);
  // ------------------------------------------------------------------
  // Architectural state
  // ------------------------------------------------------------------
  cbm_pkg::cbm_state_t state;
  logic [7:0]  acc;
  logic [7:0]  flags;
  logic [15:0] primary_pointer_pair;
  logic [15:0] destination_pointer_pair;
  logic [15:0] byte_counter_pair;
  logic [15:0] first_index_register;
  logic [15:0] second_index_register;
  logic [15:0] stack_pointer;
  logic [15:0] pc;
  logic [15:0] refresh_count;
  logic [15:0] opcode;
  logic [4:0]  tstate;
  logic [4:0]  tlimit;
  logic        rd_sync1;
  logic        rd_sync2;
  logic        int_sync1;
  logic        int_sync2;
  logic        wr_sync1;
  logic        wr_sync2;
  logic        fifo_out_valid;
  logic        fifo_in_ready;
  logic [7:0]  fifo_out_data;
  logic        pop_byte;
  logic [7:0]  rd_data_q;
  logic [7:0]  neg_res;
  logic [4:0]  neg_low;
  logic [15:0] next_bc;
  logic        is_copy;
  logic        is_asc;
  logic        is_rpt;
  logic        apb_wr;
  logic        apb_rd;
  logic [1:0]  refresh_left;

  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign busy    = (state != cbm_pkg::CBM_IDLE);

  // Read valid, write ready and interrupt cross through two flops; read data through one
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_sync1  <= 1'b0;
      rd_sync2  <= 1'b0;
      int_sync1 <= 1'b0;
      int_sync2 <= 1'b0;
      wr_sync1  <= 1'b0;
      wr_sync2  <= 1'b0;
      rd_data_q <= 8'h00;
    end
    else
    begin
      rd_sync1  <= mem_rd_valid;
      rd_sync2  <= rd_sync1;
      int_sync1 <= int_request;
      int_sync2 <= int_sync1;
      wr_sync1  <= mem_wr_ready;
      wr_sync2  <= wr_sync1;
      rd_data_q <= mem_rdata;
    end
  end

  // ------------------------------------------------------------------
  // Copy buffer between read and write phases
  // ------------------------------------------------------------------
  cbm_fifo #(
    .WIDTH (8),
    .DEPTH (4)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (state == cbm_pkg::CBM_MRD && rd_sync2 && !fifo_out_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (rd_data_q),
    .out_valid (fifo_out_valid),
    .out_ready (pop_byte),
    .out_data  (fifo_out_data)
  );

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  always_comb
  begin
    is_copy = (opcode[15:8] == cbm_pkg::OP_PFX_ED) &&
              (opcode[7:4] == 4'hA || opcode[7:4] == 4'hB) &&
              (opcode[2:0] == 3'b000);
    is_asc  = !opcode[3];
    is_rpt  = opcode[4];
    next_bc = byte_counter_pair - 16'h0001;
    neg_res = 8'h00 - acc;
    neg_low = 5'h00 - {1'b0, acc[3:0]};
  end

  always_comb
  begin
    tlimit = cbm_pkg::T_REG_LD;
    if (opcode == {8'h00, cbm_pkg::OP_LD_SP_PP})
    begin
      tlimit = cbm_pkg::T_SP_PP;
    end
    else if (opcode == {cbm_pkg::OP_PFX_IX, cbm_pkg::OP_LD_SP_PP} ||
             opcode == {cbm_pkg::OP_PFX_IY, cbm_pkg::OP_LD_SP_PP})
    begin
      tlimit = cbm_pkg::T_SP_IDX;
    end
    else if (opcode == {cbm_pkg::OP_PFX_ED, cbm_pkg::OP_NEG})
    begin
      tlimit = cbm_pkg::T_NEG;
    end
    else if (is_copy)
    begin
      tlimit = (is_rpt && next_bc != 16'h0000) ?
               cbm_pkg::T_CPY_RPT : cbm_pkg::T_CPY;
    end
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  // Memory handshakes stretch a state; the clock-state count still runs,
  // so a slow memory lengthens the pass beyond its nominal figure.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state  <= cbm_pkg::CBM_IDLE;
      tstate <= 5'h00;
    end
    else
    begin
      unique case (state)
        cbm_pkg::CBM_IDLE:
        begin
          tstate <= 5'h01;
          if (apb_wr && paddr == cbm_pkg::A_CMD)
          begin
            state <= cbm_pkg::CBM_EXEC;
          end
        end
        cbm_pkg::CBM_EXEC:
        begin
          tstate <= tstate + 5'h01;
          if (is_copy && tstate == cbm_pkg::T_RD_AT - 5'h01)
          begin
            state <= cbm_pkg::CBM_MRD;
          end
          else if (tstate >= tlimit)
          begin
            state <= cbm_pkg::CBM_DONE;
          end
        end
        cbm_pkg::CBM_MRD:
        begin
          tstate <= tstate + 5'h01;
          if (fifo_out_valid)
          begin
            state <= cbm_pkg::CBM_MWR;
          end
        end
        cbm_pkg::CBM_MWR:
        begin
          tstate <= tstate + 5'h01;
          if (wr_sync2 && tstate >= cbm_pkg::T_WR_AT)
          begin
            state <= cbm_pkg::CBM_EXEC;
          end
        end
        cbm_pkg::CBM_DONE:
        begin
          state <= cbm_pkg::CBM_IDLE;
        end
        default:
        begin
          state <= cbm_pkg::CBM_IDLE;
        end
      endcase
    end
  end

  assign pop_byte  = (state == cbm_pkg::CBM_MWR) && wr_sync2 &&
                     (tstate >= cbm_pkg::T_WR_AT);
  assign mem_rd    = (state == cbm_pkg::CBM_MRD) && fifo_in_ready &&
                     !fifo_out_valid;
  assign mem_wr    = (state == cbm_pkg::CBM_MWR);
  assign mem_wdata = fifo_out_data;
  assign mem_addr  = (state == cbm_pkg::CBM_MWR) ?
                     destination_pointer_pair : primary_pointer_pair;

  // ------------------------------------------------------------------
  // Register updates at end of instruction
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc                      <= 8'h00;
      flags                    <= 8'h00;
      primary_pointer_pair     <= 16'h0000;
      destination_pointer_pair <= 16'h0000;
      byte_counter_pair        <= 16'h0000;
      first_index_register     <= 16'h0000;
      second_index_register    <= 16'h0000;
      stack_pointer            <= 16'h0000;
      pc                       <= 16'h0000;
      opcode                   <= 16'h0000;
    end
    else if (state == cbm_pkg::CBM_IDLE)
    begin
      if (apb_wr)
      begin
        unique case (paddr)
          cbm_pkg::A_CMD:  opcode <= pwdata[15:0];
          cbm_pkg::A_ACC:  acc <= pwdata[7:0];
          cbm_pkg::A_FLG:  flags <= pwdata[7:0];
          cbm_pkg::A_PP:   primary_pointer_pair <= pwdata[15:0];
          cbm_pkg::A_DP:   destination_pointer_pair <= pwdata[15:0];
          cbm_pkg::A_BC:   byte_counter_pair <= pwdata[15:0];
          cbm_pkg::A_IX:   first_index_register <= pwdata[15:0];
          cbm_pkg::A_IY:   second_index_register <= pwdata[15:0];
          cbm_pkg::A_SP:   stack_pointer <= pwdata[15:0];
          cbm_pkg::A_PC:   pc <= pwdata[15:0];
          default:         ;
        endcase
      end
    end
    else if (state == cbm_pkg::CBM_EXEC && tstate >= tlimit)
    begin
      // PC advances by instruction length, except on a repeating copy whose count has not reached zero
      pc <= pc + ((opcode[15:8] == 8'h00) ? 16'h0001 : 16'h0002);
      if (opcode == {8'h00, cbm_pkg::OP_LD_SP_PP})
      begin
        stack_pointer <= primary_pointer_pair;
      end
      else if (opcode == {cbm_pkg::OP_PFX_IX, cbm_pkg::OP_LD_SP_PP})
      begin
        stack_pointer <= first_index_register;
      end
      else if (opcode == {cbm_pkg::OP_PFX_IY, cbm_pkg::OP_LD_SP_PP})
      begin
        stack_pointer <= second_index_register;
      end
      else if (opcode == {cbm_pkg::OP_PFX_ED, cbm_pkg::OP_NEG})
      begin
        acc              <= neg_res;
        flags[cbm_pkg::FLG_S]  <= neg_res[7];
        flags[cbm_pkg::FLG_Z]  <= (neg_res == 8'h00);
        flags[cbm_pkg::FLG_H]  <= neg_low[4];
        flags[cbm_pkg::FLG_PV] <= (acc == cbm_pkg::ACC_MIN);
        flags[cbm_pkg::FLG_N]  <= 1'b1;
        flags[cbm_pkg::FLG_C]  <= (acc != 8'h00);
      end
      else if (is_copy)
      begin
        // Pointer updates follow the write
        primary_pointer_pair     <= is_asc ? primary_pointer_pair + 16'h0001
                                    : primary_pointer_pair - 16'h0001;
        destination_pointer_pair <= is_asc ?
                                    destination_pointer_pair + 16'h0001 :
                                    destination_pointer_pair - 16'h0001;
        byte_counter_pair        <= next_bc;
        flags[cbm_pkg::FLG_H]    <= 1'b0;
        flags[cbm_pkg::FLG_N]    <= 1'b0;
        flags[cbm_pkg::FLG_PV]   <= is_rpt ? 1'b0 : (next_bc != 16'h0000);
        if (is_rpt && next_bc != 16'h0000)
        begin
          // Re-fetch the same instruction
          pc <= pc;
        end
      end
      // Plain register loads touch no flag
    end
  end

  // ------------------------------------------------------------------
  // Refresh after each transferred byte; interrupt window only after a byte of a repeating copy
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      refresh_left   <= 2'h0;
      refresh_count  <= 16'h0000;
      refresh_strobe <= 1'b0;
      int_window     <= 1'b0;
    end
    else
    begin
      refresh_strobe <= 1'b0;
      int_window     <= 1'b0;
      if (state == cbm_pkg::CBM_EXEC && tstate >= tlimit && is_copy)
      begin
        refresh_left <= cbm_pkg::REFRESH_N;
        int_window   <= is_rpt && int_sync2;
      end
      else if (refresh_left != 2'h0)
      begin
        refresh_left   <= refresh_left - 2'h1;
        refresh_strobe <= 1'b1;
        refresh_count  <= refresh_count + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------------
  // APB read
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (apb_rd)
    begin
      pslverr <= 1'b0;
      unique case (paddr)
        cbm_pkg::A_CMD:  prdata <= {16'h0000, opcode};
        cbm_pkg::A_ACC:  prdata <= {24'h000000, acc};
        cbm_pkg::A_FLG:  prdata <= {24'h000000, flags};
        cbm_pkg::A_PP:   prdata <= {16'h0000, primary_pointer_pair};
        cbm_pkg::A_DP:   prdata <= {16'h0000, destination_pointer_pair};
        cbm_pkg::A_BC:   prdata <= {16'h0000, byte_counter_pair};
        cbm_pkg::A_IX:   prdata <= {16'h0000, first_index_register};
        cbm_pkg::A_IY:   prdata <= {16'h0000, second_index_register};
        cbm_pkg::A_SP:   prdata <= {16'h0000, stack_pointer};
        cbm_pkg::A_PC:   prdata <= {16'h0000, pc};
        cbm_pkg::A_STAT: prdata <= {27'h0, tstate[1:0], state};
        cbm_pkg::A_RFSH: prdata <= {16'h0000, refresh_count};
        default:
        begin
          prdata  <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end
    else if (!penable)
    begin
      pslverr <= 1'b0;
    end
  end
endmodule : cbm_exec

// file: test/cbm_exec_asserts.sv
// Port checker for the execution unit, bound onto cbm_exec.
// Assumes one clock domain and reset_n asynchronous, active low.
`timescale 1ns/1ps
module cbm_exec_asserts (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // Memory and core joins
  input wire logic [15:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        int_window,
  input wire logic        refresh_strobe,
  input wire logic        busy
);
  logic       rd_seen;
  logic [7:0] busy_cnt;
  // Read seen in this pass; forgotten once idle
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      rd_seen <= 1'b0;
    else
      rd_seen <= busy && (rd_seen || mem_rd);
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      busy_cnt <= 8'h00;
    else
      busy_cnt <= busy ? busy_cnt + 8'h01 : 8'h00;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("apb access without ready");
  a_slverr_map: assert property (psel && penable && !pwrite |->
    pslverr == (paddr > 8'h2C || paddr[1:0] != 2'h0))
    else $error("error response wrong for read address");
  a_cmd_starts: assert property (psel && penable && pwrite && !busy &&
    paddr == cbm_pkg::A_CMD |-> ##[1:2] busy)
    else $error("command did not start execution");
  a_rd_wr_apart: assert property (!(mem_rd && mem_wr))
    else $error("read and write requested together");
  a_read_first: assert property (mem_wr |-> rd_seen)
    else $error("write without preceding read");
  a_write_steady: assert property (mem_wr && $past(mem_wr) |->
    $stable(mem_addr) && $stable(mem_wdata))
    else $error("write address or data moved");
  a_mem_quiet: assert property (!busy |-> !mem_rd && !mem_wr)
    else $error("memory request while idle");
  a_refresh_pair: assert property ($fell(mem_wr) |->
    ##[1:40] refresh_strobe ##[1:8] refresh_strobe)
    else $error("two refresh pulses missing after copy");
  a_int_pulse: assert property (int_window |=> !int_window)
    else $error("interrupt window longer than one cycle");
  a_busy_bounded: assert property (busy_cnt < 8'hC8)
    else $error("execution ran too long");
  c_write: cover property (mem_wr && $past(mem_rd, 2));
  c_int: cover property (int_window);
  c_err: cover property (pslverr);
  c_refresh: cover property (refresh_strobe);
endmodule : cbm_exec_asserts

bind cbm_exec cbm_exec_asserts i_cbm_exec_asserts (
  .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .mem_wdata(mem_wdata), .int_window(int_window),
  .refresh_strobe(refresh_strobe), .busy(busy)
);

// file: test/cbm_mem_model.sv
// Byte memory at the far side of the execution unit.
// Assumes level requests held until answered; dly sets answer delay.
`timescale 1ns/1ps
module cbm_mem_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // Memory port
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  output logic             mem_rd_valid,
  output logic      [7:0]  mem_rdata,
  output logic             mem_wr_ready,
  // Answer delay in cycles
  input  wire logic [3:0]  dly
);
  logic [7:0] mem [0:65535];
  logic [3:0] wait_cnt;
  logic       go;
  assign go = (mem_rd || mem_wr) && wait_cnt >= dly;
  initial
  begin
    for (int a = 0; a < 65536; a++)
      mem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h5A;
  end
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      wait_cnt <= 4'h0;
    else if (!(mem_rd || mem_wr))
      wait_cnt <= 4'h0;
    else if (!go)
      wait_cnt <= wait_cnt + 4'h1;
  // Idle data line toggles so a stale byte is never mistaken for data
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      mem_rd_valid <= 1'b0;
      mem_wr_ready <= 1'b0;
      mem_rdata    <= 8'hA5;
    end
    else
    begin
      mem_rd_valid <= go && mem_rd;
      mem_wr_ready <= go && mem_wr;
      mem_rdata    <= (go && mem_rd) ? mem[mem_addr] : ~mem_rdata;
    end
  always @(posedge mclk)
    if (mem_wr && mem_wr_ready)
      mem[mem_addr] <= mem_wdata;
endmodule : cbm_mem_model

// file: test/tb_cbm_exec.sv
// Self-checking bench for cbm_exec and its memory model.
// Assumes cbm_pkg, cbm_fifo, cbm_exec and cbm_mem_model compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_cbm_exec;
  typedef struct packed {
    logic [15:0] cmd;
    logic [7:0]  acc;
    logic [7:0]  fin;
    logic [7:0]  ra;
    logic [15:0] rexp;
    logic [7:0]  fexp;
    logic [4:0]  t;
  } cbm_row_t;
  logic        mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, mem_rd, mem_wr, busy, err;
  logic [7:0]  paddr = 8'h00, mem_wdata, mem_rdata;
  logic [31:0] pwdata = 32'h0, prdata, q, cnt, pc0, rf;
  logic [15:0] mem_addr;
  logic        mem_rd_valid, mem_wr_ready, int_window, refresh_strobe;
  logic        int_request = 1'b0;
  logic [3:0]  dly = 4'h0;
  int          checked = 0, n_fail = 0, n_int = 0, k;
  cbm_row_t    rows [9] = '{
    '{16'h0000, 8'h12, 8'hD7, 8'h04, 16'h0012, 8'hD7, 5'h04},
    '{16'h0053, 8'h12, 8'hD7, 8'h04, 16'h0012, 8'hD7, 5'h04},
    '{16'h00F9, 8'h12, 8'hD7, 8'h20, 16'h442E, 8'hD7, 5'h06},
    '{16'hDDF9, 8'h12, 8'hD7, 8'h20, 16'h98DA, 8'hD7, 5'h0A},
    '{16'hFDF9, 8'h12, 8'hD7, 8'h20, 16'hA227, 8'hD7, 5'h0A},
    '{16'hED44, 8'h98, 8'h00, 8'h04, 16'h0068, 8'h13, 5'h08},
    '{16'hED44, 8'h80, 8'h00, 8'h04, 16'h0080, 8'h87, 5'h08},
    '{16'hED44, 8'h00, 8'h00, 8'h04, 16'h0000, 8'h42, 5'h08},
    '{16'hED44, 8'h01, 8'h00, 8'h04, 16'h00FF, 8'h93, 5'h08}};
  always #5 mclk = ~mclk;
  always @(posedge mclk)
    if (int_window === 1'b1)
      n_int++;
  cbm_exec i_cbm_exec (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rd_valid(mem_rd_valid),
    .mem_rdata(mem_rdata), .mem_wr_ready(mem_wr_ready),
    .int_request(int_request), .int_window(int_window),
    .refresh_strobe(refresh_strobe), .busy(busy));
  cbm_mem_model i_cbm_mem_model (.mclk(mclk), .reset_n(reset_n),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rd_valid(mem_rd_valid),
    .mem_rdata(mem_rdata), .mem_wr_ready(mem_wr_ready), .dly(dly));
  // ----------------------------------------------------------------
  // Bus and command tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic run_cmd(input logic [15:0] c);
    cnt = 32'h0;
    apb(1'b1, cbm_pkg::A_CMD, {16'h0, c});
    while (busy === 1'b1 && cnt < 32'd2000)
    begin
      cnt++;
      @(posedge mclk);
    end
    if (busy === 1'b1)
      n_fail++;
  endtask : run_cmd
  task automatic copy(input logic [15:0] pp, dp, bc, c);
    apb(1'b1, cbm_pkg::A_PP, {16'h0, pp});
    apb(1'b1, cbm_pkg::A_DP, {16'h0, dp});
    apb(1'b1, cbm_pkg::A_BC, {16'h0, bc});
    apb(1'b1, cbm_pkg::A_FLG, 32'hD7);
    run_cmd(c);
  endtask : copy
  task automatic regs(input logic [15:0] pp, dp, bc, input [7:0] f);
    apb(1'b0, cbm_pkg::A_PP, 32'h0);
    `CHK("source", {16'h0, pp}, q)
    apb(1'b0, cbm_pkg::A_DP, 32'h0);
    `CHK("dest", {16'h0, dp}, q)
    apb(1'b0, cbm_pkg::A_BC, 32'h0);
    `CHK("count", {16'h0, bc}, q)
    apb(1'b0, cbm_pkg::A_FLG, 32'h0);
    `CHK("flags", {24'h0, f}, q & 32'hD7)
  endtask : regs
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    apb(1'b1, cbm_pkg::A_PP, 32'h442E);
    apb(1'b1, cbm_pkg::A_IX, 32'h98DA);
    apb(1'b1, cbm_pkg::A_IY, 32'hA227);
    foreach (rows[i])
    begin
      apb(1'b1, cbm_pkg::A_ACC, {24'h0, rows[i].acc});
      apb(1'b1, cbm_pkg::A_FLG, {24'h0, rows[i].fin});
      run_cmd(rows[i].cmd);
      `CHK("states", {27'h0, rows[i].t} + 32'h1, cnt)
      apb(1'b0, rows[i].ra, 32'h0);
      `CHK("result", {16'h0, rows[i].rexp}, q)
      apb(1'b0, cbm_pkg::A_FLG, 32'h0);
      `CHK("flag", {24'h0, rows[i].fexp}, q & 32'hD7)
    end
    $display("test table done");
    copy(16'h1111, 16'h2222, 16'h0007, 16'hEDA8);
    `CHK("copy time", 1'b1, cnt > 32'd16)
    regs(16'h1110, 16'h2221, 16'h0006, 8'hC5);
    `CHK("byte", i_cbm_mem_model.mem[4369], i_cbm_mem_model.mem[8738])
    copy(16'h1111, 16'h3333, 16'h0001, 16'hEDA0);
    regs(16'h1112, 16'h3334, 16'h0000, 8'hC1);
    `CHK("byte", i_cbm_mem_model.mem[4369], i_cbm_mem_model.mem[13107])
    $display("test single copies done");
    dly <= 4'h3;
    int_request <= 1'b1;
    apb(1'b0, cbm_pkg::A_PC, 32'h0);
    pc0 = q;
    apb(1'b0, cbm_pkg::A_RFSH, 32'h0);
    rf = q;
    copy(16'h1111, 16'h4444, 16'h0003, 16'hEDB0);
    for (int p = 0; p < 2; p++)
    begin
      `CHK("pass time", 1'b1, cnt > 32'd21)
      apb(1'b0, cbm_pkg::A_PC, 32'h0);
      `CHK("held pc", pc0, q)
      run_cmd(16'hEDB0);
    end
    regs(16'h1114, 16'h4447, 16'h0000, 8'hC1);
    for (k = 0; k < 3; k++)
      `CHK("block", i_cbm_mem_model.mem[4369 + k], i_cbm_mem_model.mem[17476 + k])
    apb(1'b0, cbm_pkg::A_RFSH, 32'h0);
    `CHK("refresh", 32'd6, q - rf)
    `CHK("int seen", 1'b1, n_int > 0)
    copy(16'h1114, 16'h5555, 16'h0002, 16'hEDB8);
    run_cmd(16'hEDB8);
    regs(16'h1112, 16'h5553, 16'h0000, 8'hC1);
    for (k = 0; k < 2; k++)
      `CHK("down", i_cbm_mem_model.mem[4372-k], i_cbm_mem_model.mem[21845-k])
    copy(16'h1111, 16'h6666, 16'h0000, 16'hEDB8);
    apb(1'b0, cbm_pkg::A_BC, 32'h0);
    `CHK("wrap", 32'hFFFF, q)
    apb(1'b0, cbm_pkg::A_PC, 32'h0);
    `CHK("wrap pc", pc0 + 32'd4, q)
    apb(1'b0, cbm_pkg::A_PP, 32'h0);
    `CHK("wrap src", 32'h1110, q)
    `CHK("wrap byte", i_cbm_mem_model.mem[4369], i_cbm_mem_model.mem[26214])
    $display("test repeats done");
    apb(1'b1, cbm_pkg::A_ACC, 32'h02);
    apb(1'b1, cbm_pkg::A_CMD, 32'hED44);
    apb(1'b1, cbm_pkg::A_ACC, 32'h55);
    while (busy === 1'b1)
      @(posedge mclk);
    apb(1'b0, cbm_pkg::A_ACC, 32'h0);
    `CHK("busy write", 32'hFE, q)
    apb(1'b0, 8'h3C, 32'h0);
    `CHK("unmapped", 1'b1, err)
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    apb(1'b0, cbm_pkg::A_SP, 32'h0);
    `CHK("sp reset", 32'h0, q)
    $display("test refusal and reset done");
    finish_test();
  end
  initial
  begin
    #300000;
    n_fail++;
    finish_test();
  end
endmodule : tb_cbm_exec
